// [logic/dbe_device.sv]
// Bank select and data EEPROM device end of the data space bus
`timescale 1ns/1ns
`include "dbe_cfg.svh"
module dbe_device (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Data space bus
  dbe_ds_if.dev            bus,
  // Status
  output logic             nv_standby,
  output logic             nv_busy_flag,
  output logic      [7:0]  page_select_reg
);
  // Control register state
  logic                    nv_program_enable_r;  // Programming enable
  logic                    row_mode_enable_r;    // Row write mode
  logic                    busy_r;               // Programming running
  dbe_pkg::dbe_prog_t      st_r;                 // Sequencer state
  dbe_pkg::dbe_prog_t      st_nxt;
  logic [`DBE_CNT_W-1:0]   cnt_r;                // Cycles left in programming
  // Row tracking
  logic                    row_held_r;           // Row address latched
  logic [3:0]              row_r;                // Page bit and A5..A3
  // Byte mode capture
  logic [6:0]              bp_addr_r;
  logic [7:0]              bp_data_r;
  // Bus answer
  logic                    ack_r;
  logic [7:0]              rdata_r;
  logic [7:0]              rd_nxt;
  // Storage: two EEPROM pages, two RAM and two display pages
  logic [7:0]              ee_mem [0:127] = '{default: `DBE_ERASED};
  logic [7:0]              ram_mem [0:255];
  // Row latch contents
  logic [63:0]             row_data;
  logic [7:0]              row_mask;

  // Control reset image; a named constant so its bits can be selected
  localparam logic [7:0] CTL_RST = `DBE_CTL_RESET;

  // Address decode
  wire       in_win   = (bus.addr[7:6] == 2'b00);
  wire       acc      = bus.rd | bus.wr;
  wire       ps_wr    = bus.wr & (bus.addr == `DBE_ADDR_PAGE_SEL);
  wire       ctl_hit  = (bus.addr == `DBE_ADDR_NV_CTRL);
  wire       ctl_wr   = bus.wr & ctl_hit & ~busy_r;
  // EEPROM page decode; value zero selects nothing
  wire       ee_sel   = page_select_reg[`DBE_PS_EE0] | page_select_reg[`DBE_PS_EE1];
  wire       ee_page  = page_select_reg[`DBE_PS_EE1];
  // EEPROM usable only selected, awake and idle
  wire       ee_ok    = in_win & ee_sel & ~nv_standby & ~busy_r;
  wire [6:0] ee_idx   = {ee_page, bus.addr[5:0]};
  // Row is the page bit plus A5..A3; A2..A0 pick the latch
  wire [3:0] acc_row  = {ee_page, bus.addr[5:3]};
  wire       row_hit  = ~row_held_r | (row_r == acc_row);
  // Control write decode
  wire       mode_wr  = bus.wdata[`DBE_CTL_MODE];
  wire       mode_set = ctl_wr & mode_wr & ~row_mode_enable_r;
  wire       mode_off = ctl_wr & ~mode_wr;
  // Start only with enable and row mode both set
  wire       row_go   = ctl_wr & bus.wdata[`DBE_CTL_START] & bus.wdata[`DBE_CTL_ENABLE]
                        & row_mode_enable_r & mode_wr;
  // Byte mode write programs straight away when enabled
  wire       byte_go  = bus.wr & ee_ok & nv_program_enable_r & ~row_mode_enable_r;
  // Row mode writes fill latches of the held row only
  wire       latch_wr = bus.wr & ee_ok & row_mode_enable_r & row_hit;
  wire       row_grab = acc & ee_ok & row_mode_enable_r & ~row_held_r;
  wire       go       = byte_go | row_go;
  wire       done     = busy_r & (cnt_r == `DBE_CNT_W'(1));

  // Row latches, emptied whenever row mode is entered
  dbe_row_latch u_row (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (mode_set),
    .load     (latch_wr),
    .idx      (bus.addr[2:0]),
    .din      (bus.wdata),
    .row_data (row_data),
    .row_mask (row_mask)
  );

  // Page select: no reset, so software must load it before use
  always_ff @(posedge aclk) begin
    if (ps_wr) begin
      page_select_reg <= bus.wdata;
    end
  end

  // Control bits; writes blocked while programming runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_standby          <= CTL_RST[`DBE_CTL_STANDBY];
      nv_program_enable_r <= CTL_RST[`DBE_CTL_ENABLE];
      row_mode_enable_r   <= CTL_RST[`DBE_CTL_MODE];
    end else if (ctl_wr) begin
      // Bits 1, 3, 4, 5 and 7 are not stored
      nv_standby          <= bus.wdata[`DBE_CTL_STANDBY];
      nv_program_enable_r <= bus.wdata[`DBE_CTL_ENABLE];
      row_mode_enable_r   <= mode_wr;
    end else if (done) begin
      row_mode_enable_r   <= 1'b0;
    end
  end

  // Row address capture on the first EEPROM access in row mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_held_r <= 1'b0;
      row_r      <= 4'h0;
    end else if (mode_set || mode_off || done) begin
      row_held_r <= 1'b0;
    end else if (row_grab) begin
      row_held_r <= 1'b1;
      row_r      <= acc_row;
    end
  end

  // Byte mode keeps only the one byte being programmed
  always_ff @(posedge aclk) begin
    if (byte_go) begin
      bp_addr_r <= ee_idx;
      bp_data_r <= bus.wdata;
    end
  end

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dbe_pkg::dbe_prog_idle: begin
        if (byte_go) begin
          st_nxt = dbe_pkg::dbe_prog_byte;
        end else if (row_go) begin
          st_nxt = dbe_pkg::dbe_prog_row;
        end
      end
      dbe_pkg::dbe_prog_byte,
      dbe_pkg::dbe_prog_row: begin
        if (done) begin
          st_nxt = dbe_pkg::dbe_prog_idle;
        end
      end
      default: begin
        st_nxt = dbe_pkg::dbe_prog_idle;
      end
    endcase
  end

  // Sequencer, busy flag and cycle counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= dbe_pkg::dbe_prog_idle;
      busy_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      busy_r <= go | (busy_r & ~done);
      if (go) begin
        cnt_r <= `DBE_PROG_CYCLES;
      end else if (busy_r) begin
        cnt_r <= cnt_r - `DBE_CNT_W'(1);
      end
    end
  end

  // Cells change only when the programming cycle completes
  always_ff @(posedge aclk) begin
    if (done && st_r == dbe_pkg::dbe_prog_byte) begin
      ee_mem[bp_addr_r] <= bp_data_r;
    end
    if (done && st_r == dbe_pkg::dbe_prog_row) begin
      for (int i = 0; i < 8; i++) begin
        if (row_mask[i]) begin
          ee_mem[{row_r, 3'(i)}] <= row_data[8*i +: 8];
        end
      end
    end
  end

  // RAM and display pages; several select bits write several pages
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (bus.wr && in_win && page_select_reg[`DBE_PS_RAM1 + i]) begin
        ram_mem[{2'(i), bus.addr[5:0]}] <= bus.wdata;
      end
    end
  end

  // Read mux; pages read together OR their data, as a hazard
  always_comb begin
    rd_nxt = `DBE_VOID_DATA;
    if (ctl_hit) begin
      rd_nxt[`DBE_CTL_BUSY] = busy_r;
    end else if (in_win) begin
      // No EEPROM data in standby, busy or row mode
      if (ee_ok && !row_mode_enable_r) begin
        rd_nxt = ee_mem[ee_idx];
      end
      for (int i = 0; i < 4; i++) begin
        if (page_select_reg[`DBE_PS_RAM1 + i]) begin
          rd_nxt = rd_nxt | ram_mem[{2'(i), bus.addr[5:0]}];
        end
      end
    end
  end

  // Every access is answered one cycle later at the same speed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r   <= 1'b0;
      rdata_r <= `DBE_VOID_DATA;
    end else begin
      ack_r   <= acc;
      rdata_r <= rd_nxt;
    end
  end

  // Outputs
  assign bus.ack      = ack_r;
  assign bus.rdata    = rdata_r;
  assign nv_busy_flag = busy_r;
endmodule

// [logic/dbe_cfg.svh]
// Constants for the data bank select and nonvolatile data controller
`ifndef DBE_CFG_SVH
`define DBE_CFG_SVH
// Data space register addresses
`define DBE_ADDR_PAGE_SEL 8'hcb
`define DBE_ADDR_NV_CTRL  8'hdf
// Control register fields and reset value
`define DBE_CTL_ENABLE    0
`define DBE_CTL_BUSY      1
`define DBE_CTL_MODE      2
`define DBE_CTL_START     3
`define DBE_CTL_STANDBY   6
`define DBE_CTL_RESET     8'h00
// Page select bit positions
`define DBE_PS_EE0        0
`define DBE_PS_EE1        1
`define DBE_PS_RAM1       3
// Data values
`define DBE_ERASED        8'hff
`define DBE_VOID_DATA     8'h00
// Programming cycle length in clock cycles
`define DBE_PROG_CYCLES   12'd1000
`define DBE_CNT_W         12
// Controller register byte offsets
`define DBE_HR_ADDR       8'h00
`define DBE_HR_WDATA      8'h04
`define DBE_HR_CMD        8'h08
`define DBE_HR_STATUS     8'h0c
`define DBE_CMD_RD        0
`define DBE_CMD_WR        1
`define DBE_AXI_OKAY      2'b00
`define DBE_AXI_SLVERR    2'b10
`endif

// [logic/dbe_pkg.sv]
// Types shared by both ends of the data space link
package dbe_pkg;
  // Programming sequencer states
  typedef enum logic [2:0] {
    dbe_prog_idle = 3'b001,
    dbe_prog_byte = 3'b010,
    dbe_prog_row  = 3'b100
  } dbe_prog_t;
  // Controller access states
  typedef enum logic [1:0] {
    dbe_hst_idle = 2'b01,
    dbe_hst_wait = 2'b10
  } dbe_hst_t;
endpackage

// [logic/dbe_ds_if.sv]
// Data space bus between processor side and the bank/EEPROM device
`timescale 1ns/1ns
interface dbe_ds_if;
  logic [7:0] addr;   // Data space address
  logic [7:0] wdata;  // Write data
  logic       wr;     // One-cycle write strobe
  logic       rd;     // One-cycle read strobe
  logic [7:0] rdata;  // Read data, valid with ack
  logic       ack;    // One-cycle answer
  modport core (output addr, wdata, wr, rd, input rdata, ack);
  modport dev  (input addr, wdata, wr, rd, output rdata, ack);
endinterface

// [logic/dbe_row_latch.sv]
// Eight volatile row latches with a written mask
`timescale 1ns/1ns
module dbe_row_latch (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        clear,
  input  wire logic        load,
  input  wire logic [2:0]  idx,
  input  wire logic [7:0]  din,
  // Contents
  output logic      [63:0] row_data,
  output logic      [7:0]  row_mask
);
  // Latches start empty; clear wins over a load in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      row_data <= 64'h0;
      row_mask <= 8'h00;
    end else if (load) begin
      row_data[{idx, 3'b000} +: 8] <= din;
      row_mask[idx]                <= 1'b1;
    end
  end
endmodule

// [logic/dbe_host.sv]
// Controller end: AXI4-Lite registers that drive data space accesses
`timescale 1ns/1ns
`include "dbe_cfg.svh"
module dbe_host (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Data space bus
  dbe_ds_if.core           bus
);
  logic [7:0]         aw_addr_r;   // Held write address
  logic               aw_have_r;
  logic [7:0]         w_data_r;    // Held low byte of write data
  logic               w_strb_r;
  logic               w_have_r;
  logic [7:0]         addr_r;      // Target data space address
  logic [7:0]         wdat_r;      // Data for a data space write
  logic               rd_r;
  logic               wr_r;
  logic [7:0]         last_r;      // Last read data
  logic               done_r;      // Access finished
  dbe_pkg::dbe_hst_t  st_r;

  // Handshakes and decode
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_wr   = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire wr_ok   = (aw_addr_r[7:4] == 4'h0) & (aw_addr_r[1:0] == 2'b00);
  wire wr_en   = do_wr & wr_ok & w_strb_r;
  wire cmd_wr  = wr_en & (aw_addr_r == `DBE_HR_CMD) & (st_r == dbe_pkg::dbe_hst_idle);
  wire pend    = (st_r == dbe_pkg::dbe_hst_wait);
  wire rd_ok   = (s_axi_araddr[7:4] == 4'h0) & (s_axi_araddr[1:0] == 2'b00);
  wire [31:0] status = {16'h0, last_r, 6'h0, done_r, pend};

  // Write channels are taken independently, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DBE_AXI_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DBE_AXI_OKAY : `DBE_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
    end
  end

  // Address and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r <= 8'h00;
      wdat_r <= 8'h00;
    end else if (wr_en && aw_addr_r == `DBE_HR_ADDR) begin
      addr_r <= w_data_r;
    end else if (wr_en && aw_addr_r == `DBE_HR_WDATA) begin
      wdat_r <= w_data_r;
    end
  end

  // One access at a time; a command while one is pending is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= dbe_pkg::dbe_hst_idle;
      rd_r   <= 1'b0;
      wr_r   <= 1'b0;
      done_r <= 1'b0;
      last_r <= 8'h00;
    end else begin
      rd_r <= cmd_wr & w_data_r[`DBE_CMD_RD];
      wr_r <= cmd_wr & w_data_r[`DBE_CMD_WR] & ~w_data_r[`DBE_CMD_RD];
      if (cmd_wr && (w_data_r[`DBE_CMD_RD] || w_data_r[`DBE_CMD_WR])) begin
        st_r   <= dbe_pkg::dbe_hst_wait;
        done_r <= 1'b0;
      end else if (pend && bus.ack) begin
        st_r   <= dbe_pkg::dbe_hst_idle;
        done_r <= 1'b1;
        last_r <= bus.rdata;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `DBE_AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? `DBE_AXI_OKAY : `DBE_AXI_SLVERR;
        unique case (s_axi_araddr)
          `DBE_HR_ADDR:   s_axi_rdata <= {24'h0, addr_r};
          `DBE_HR_WDATA:  s_axi_rdata <= {24'h0, wdat_r};
          `DBE_HR_STATUS: s_axi_rdata <= status;
          default:        s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Bus drive straight from flops
  assign bus.addr  = addr_r;
  assign bus.wdata = wdat_r;
  assign bus.rd    = rd_r;
  assign bus.wr    = wr_r;
endmodule

// [verification/dbe_properties.sv]
// Concurrent checks on the data space bus joining host and device
`timescale 1ns/1ns
`include "dbe_cfg.svh"
module dbe_properties (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Data space bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  // Device status
  input wire logic       nv_standby,
  input wire logic       nv_busy_flag,
  input wire logic [7:0] page_select_reg
);
  localparam int PROG_N = `DBE_PROG_CYCLES;
  logic [15:0] busy_cnt_r;  // Cycles busy has stood high
  // Read of a selected EEPROM page; multi-bit selects are left out as undefined
  wire         ee_rd = rd && addr < 8'h40 &&
                       (page_select_reg == 8'h01 || page_select_reg == 8'h02);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Count busy cycles so the length is judged where busy falls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= nv_busy_flag ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  a_ack_after_req: assert property ((wr || rd) |=> ack)
    else $error("no answer one cycle after a strobe");
  a_ack_has_cause: assert property (ack |-> $past(wr || rd))
    else $error("answer without a strobe");
  a_standby_void: assert property (ee_rd && nv_standby |=> rdata == 8'h00)
    else $error("EEPROM data seen in standby");
  a_busy_void: assert property (ee_rd && nv_busy_flag |=> rdata == 8'h00)
    else $error("EEPROM data seen while busy");
  a_ctl_read_busy: assert property (rd && addr == 8'hdf |=>
    rdata == {6'h00, $past(nv_busy_flag), 1'b0})
    else $error("control read does not show busy alone");
  a_sel_read_zero: assert property (rd && addr == 8'hcb |=> rdata == 8'h00)
    else $error("page select read back");
  a_busy_length: assert property ($fell(nv_busy_flag) |-> busy_cnt_r == PROG_N)
    else $error("busy length wrong");
  a_busy_cause: assert property ($rose(nv_busy_flag) |-> $past(wr) || $past(wr, 2))
    else $error("busy rose without a write");
  a_standby_cause: assert property ($changed(nv_standby) |->
    $past(wr && addr == 8'hdf && !nv_busy_flag) && nv_standby == $past(wdata[6]))
    else $error("standby changed without a control write");
  // Main scenarios reached
  c_prog_end: cover property ($fell(nv_busy_flag));
  c_busy_read: cover property (ee_rd && nv_busy_flag);
  c_standby_on: cover property ($rose(nv_standby));
endmodule

// [verification/data_bank_select_eeprom_ctrl_bench.sv]
// Self-checking bench: AXI4-Lite host driving the bank/EEPROM device
`timescale 1ns/1ns
`include "dbe_cfg.svh"
module data_bank_select_eeprom_ctrl_bench;
  // Clock, reset, AXI4-Lite
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  // Device status
  logic        nv_standby, nv_busy_flag;
  logic [7:0]  page_select_reg;
  // Bench state
  int          err_count, comparisons;
  logic [31:0] rnd, q;        // LFSR state, last AXI read
  logic [1:0]  resp;          // Last AXI response
  logic [7:0]  d, ea;         // Last bus read, EEPROM address
  logic [7:0]  v [4];         // Written values
  // Zero and single-bit select values only
  logic [7:0]  sel_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
  logic [7:0]  row_a [3] = '{8'h18, 8'h1a, 8'h1b};
  localparam logic [7:0] SEL = `DBE_ADDR_PAGE_SEL;
  localparam logic [7:0] CTL = `DBE_ADDR_NV_CTRL;
  dbe_ds_if ds_bus ();
  dbe_host dbe_host_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus(ds_bus));
  dbe_device dbe_device_inst (.aclk, .aresetn, .bus(ds_bus), .nv_standby, .nv_busy_flag,
    .page_select_reg);
  dbe_properties dbe_properties_inst (.aclk, .aresetn, .addr(ds_bus.addr),
    .wdata(ds_bus.wdata), .wr(ds_bus.wr), .rd(ds_bus.rd), .rdata(ds_bus.rdata),
    .ack(ds_bus.ack), .nv_standby, .nv_busy_flag, .page_select_reg);
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Control read shows busy in bit 1 only
  function automatic logic [7:0] ctl_exp(input logic busy);
    return {6'h00, busy, 1'b0};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Write address and data offered together, each dropped when taken
  task axi_wr(input logic [7:0] a, input logic [7:0] dat);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1'b1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task axi_rd(input logic [7:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1'b1;
        q = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  // One data space access through the host registers, polled to done
  task ds_op(input logic [7:0] a, input logic [7:0] dat, input logic [7:0] cmd);
    axi_wr(`DBE_HR_ADDR, a);
    axi_wr(`DBE_HR_WDATA, dat);
    axi_wr(`DBE_HR_CMD, cmd);
    q = 32'h1;
    for (int n = 0; n < 20 && q[1:0] !== 2'b10; n++) axi_rd(`DBE_HR_STATUS);
    check(q[1:0], 2'b10);
    d = q[15:8];
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] dat);
    ds_op(a, dat, 8'h02);
  endtask
  task rd8(input logic [7:0] a);
    ds_op(a, 8'h00, 8'h01);
  endtask
  // Bounded wait for the programming cycle to end
  task wait_idle;
    for (int n = 0; n < 1200 && nv_busy_flag !== 1'b0; n++) @(posedge aclk);
    check(nv_busy_flag, 1'b0);
  endtask
  // Hang guard, well beyond the three programming cycles
  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    aresetn = 1'b0;
    s_axi_wstrb = 4'hf;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    err_count = 0;
    comparisons = 0;
    rnd = 32'h1388c17c;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and bus error answers
    rd8(CTL);
    check(d, ctl_exp(1'b0));
    check(nv_standby, 1'b0);
    axi_rd(`DBE_HR_ADDR);
    check(q, {24'h000000, CTL});
    axi_rd(8'h10);
    check(q, 32'h00000000);
    check(resp, `DBE_AXI_SLVERR);
    axi_wr(8'h06, 8'h00);
    check(resp, `DBE_AXI_SLVERR);
    $display("test reset done");
    // Each select value in the table, write only
    foreach (sel_tab[i]) begin
      wr8(SEL, sel_tab[i]);
      check(page_select_reg, sel_tab[i]);
      rd8(SEL);
      check(d, 8'h00);
    end
    // RAM and display pages hold separate data at one window address
    rnd = lfsr(rnd);
    ea = {2'b00, rnd[5:0]};
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      v[i] = rnd[7:0];
      wr8(SEL, sel_tab[i + 3]);
      wr8(ea, v[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr8(SEL, sel_tab[i + 3]);
      rd8(ea);
      check(d, v[i]);
    end
    wr8(SEL, 8'h00);
    rd8(ea);
    check(d, 8'h00);
    $display("test pages done");
    // Byte mode, refused and then programmed
    wr8(SEL, 8'h01);
    rnd = lfsr(rnd);
    ea = {4'h0, rnd[3:0]};
    v[0] = rnd[15:8];
    rd8(ea);
    check(d, `DBE_ERASED);
    wr8(ea, v[0]);
    check(nv_busy_flag, 1'b0);
    wr8(CTL, 8'h01);
    wr8(ea, v[0]);
    check(nv_busy_flag, 1'b1);
    rd8(CTL);
    check(d, ctl_exp(1'b1));
    wr8(CTL, 8'h40);
    check(nv_standby, 1'b0);
    rd8(ea);
    check(d, 8'h00);
    wait_idle;
    rd8(ea);
    check(d, v[0]);
    wr8(SEL, 8'h02);
    rd8(ea);
    check(d, `DBE_ERASED);
    // Standby hides the EEPROM
    wr8(SEL, 8'h01);
    wr8(CTL, 8'h40);
    check(nv_standby, 1'b1);
    rd8(ea);
    check(d, 8'h00);
    wr8(CTL, 8'h01);
    // Read and write both asked: the read wins
    ds_op(ea, 8'h00, 8'h03);
    check(d, v[0]);
    $display("test byte done");
    // Row program of three bytes, stray write to another row
    wr8(CTL, 8'h05);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      v[i] = rnd[7:0];
      wr8(row_a[i], v[i]);
    end
    wr8(8'h20, 8'h5a);
    wr8(CTL, 8'h0d);
    check(nv_busy_flag, 1'b1);
    wait_idle;
    for (int i = 0; i < 3; i++) begin
      rd8(row_a[i]);
      check(d, v[i]);
    end
    rd8(8'h1f);
    check(d, `DBE_ERASED);
    rd8(8'h20);
    check(d, `DBE_ERASED);
    // Row mode gone after the cycle: a plain write programs at once
    wr8(8'h21, 8'ha5);
    check(nv_busy_flag, 1'b1);
    wait_idle;
    // Start without enable, then abandon the row
    wr8(CTL, 8'h04);
    wr8(8'h30, 8'h3c);
    wr8(CTL, 8'h0c);
    check(nv_busy_flag, 1'b0);
    wr8(CTL, 8'h01);
    rd8(8'h30);
    check(d, `DBE_ERASED);
    $display("test row done");
    // Reset in mid-run keeps the select register
    wr8(SEL, 8'h10);
    wr8(CTL, 8'h40);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(page_select_reg, 8'h10);
    check(nv_standby, 1'b0);
    $display("test rerun reset done");
    tally_and_finish;
  end
endmodule
